// [common/esr_pkg.sv]
// constants for the exception status register bank
package esr_pkg;
  // control bus register addresses
  localparam logic [7:0] EXC_STATUS_ADDR = 8'h2c;
  localparam logic [7:0] EXC_MASK_ADDR = 8'h2d;
  // bit positions inside both registers
  localparam int PHY_PAR_BIT = 0;
  localparam int CB_PAR_BIT = 5;
  localparam int CMD_ERR_BIT = 6;
  localparam int CWI_BIT = 7;
  // bits that really exist in the status register
  localparam logic [7:0] STATUS_IMPL = 8'he1;
  // bits that exist in the mask register (bit 7 always zero)
  localparam logic [7:0] MASK_IMPL = 8'h61;
  // values after reset
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  // one cycle from request to acknowledge
  localparam int ACK_CYCLES = 1;
  // access sequencer states, one-hot
  typedef enum logic [1:0] {
    ESR_IDLE = 2'b01,
    ESR_ACK = 2'b10
  } esr_state_t;
endpackage

// [design/esr_exception_bank.sv]
// exception status and mask registers on the control bus
`timescale 1ns/1ps
module esr_exception_bank import esr_pkg::*; (
  clock,
  rst,
  phyIndicateData,
  phyIndicateParity,
  phyDataValid,
  phyParityEnable,
  ctrlBusParityEnable,
  cbReq,
  cbWrite,
  cbAddr,
  ctrlBusData,
  ctrlBusParity,
  cbIllegal,
  compareValue,
  condWriteTarget,
  condWriteDone,
  condWriteMatch,
  cbRdData,
  cbAck,
  exceptionSummaryIrq
);
  input wire logic clock;                 // 250 MHz system clock
  input wire logic rst;                   // synchronous, active high
  input wire logic [7:0] phyIndicateData; // phy indication byte
  input wire logic phyIndicateParity;     // its parity bit
  input wire logic phyDataValid;          // byte present this cycle
  input wire logic phyParityEnable;       // mode bit: check phy parity
  input wire logic ctrlBusParityEnable;   // mode bit: check bus parity
  input wire logic cbReq;                 // one-cycle access request
  input wire logic cbWrite;               // 1 write, 0 read
  input wire logic [7:0] cbAddr;          // register address
  input wire logic [7:0] ctrlBusData;     // write data
  input wire logic ctrlBusParity;         // write data parity
  input wire logic cbIllegal;             // access rules forbid this one
  input wire logic [7:0] compareValue;    // compare register contents
  input wire logic condWriteTarget;       // other bank took a cond write
  input wire logic condWriteDone;         // other bank's write finished
  input wire logic condWriteMatch;        // its compare matched
  output logic [7:0] cbRdData;            // read data, registered
  output logic cbAck;                     // one-cycle acknowledge
  output logic exceptionSummaryIrq;       // summary bit toward interrupts

  //////////////////////////////////////////////////////////////////////
  // parity checkers

  logic phyParErr;  // raw phy parity fault
  logic cbParErr;   // raw control bus parity fault

  // phy data are on this clock already, so no synchroniser is needed
  esr_parity_chk phyChk (
    .data(phyIndicateData),
    .parity(phyIndicateParity),
    .enable(phyParityEnable & phyDataValid),
    .parityErr(phyParErr)
  );

  // bus parity only matters on writes
  esr_parity_chk cbChk (
    .data(ctrlBusData),
    .parity(ctrlBusParity),
    .enable(ctrlBusParityEnable & cbReq & cbWrite),
    .parityErr(cbParErr)
  );

  //////////////////////////////////////////////////////////////////////
  // register state

  logic [7:0] status_r;     // exception status flags
  logic [7:0] status_nxt;
  logic [7:0] mask_r;       // exception mask
  logic [7:0] mask_nxt;
  logic [7:0] rdData_r;     // read data latch
  logic [7:0] rdData_nxt;
  logic ack_r;              // acknowledge
  logic ack_nxt;
  logic summary_r;          // exception summary
  logic summary_nxt;
  esr_state_t state_r;      // access sequencer
  esr_state_t state_nxt;

  logic hitStatus;          // request addresses the status register
  logic hitMask;            // request addresses the mask register
  logic execOk;             // access may be performed
  logic [7:0] events;       // hardware events this cycle

  // address decode
  always_comb begin
    hitStatus = 1'b0;
    hitMask = 1'b0;
    if (cbAddr == EXC_STATUS_ADDR) begin
      hitStatus = 1'b1;
    end else if (cbAddr == EXC_MASK_ADDR) begin
      hitMask = 1'b1;
    end
  end

  // an access runs only when legal and, for writes, with good parity
  always_comb begin
    execOk = cbReq & ~cbIllegal & ~cbParErr;
  end

  // collect this cycle's events into one byte
  always_comb begin
    events = 8'h00;
    events[PHY_PAR_BIT] = phyParErr;
    events[CB_PAR_BIT] = cbParErr;
    events[CMD_ERR_BIT] = cbReq & cbIllegal;
    // a status write whose compare differs fails and is flagged
    if (execOk && cbWrite && hitStatus) begin
      events[CWI_BIT] = (compareValue != status_r);
    end
    // conditional writes to other registers report here too; ORed so a
    // same-cycle failure on the status register is not masked by them
    if (condWriteTarget && condWriteDone) begin
      events[CWI_BIT] = events[CWI_BIT] | ~condWriteMatch;
    end
  end

  // next flag and mask values
  always_comb begin
    status_nxt = status_r;
    mask_nxt = mask_r;
    // conditional write to status: only when compare matches
    if (execOk && cbWrite && hitStatus) begin
      // on mismatch the old contents stay untouched
      if (compareValue == status_r) begin
        status_nxt = ctrlBusData & STATUS_IMPL;
      end
    end
    // mask writes are unconditional; bit 7 cannot be set
    if (execOk && cbWrite && hitMask) begin
      mask_nxt = ctrlBusData & MASK_IMPL;
    end
    // events are ORed last so a set beats a same-cycle clear
    status_nxt = (status_nxt | events) & STATUS_IMPL;
  end

  // summary follows the masked flags; mask bit 7 is held at zero
  always_comb begin
    summary_nxt = |(status_nxt & mask_nxt & ~8'h80);
  end

  // read data and acknowledge sequencing
  always_comb begin
    rdData_nxt = rdData_r;
    ack_nxt = 1'b0;
    state_nxt = state_r;
    case (state_r)
      ESR_IDLE: begin
        if (cbReq) begin
          ack_nxt = 1'b1;
          state_nxt = ESR_ACK;
          rdData_nxt = 8'h00;
          // reads return data only when legal, else zero; reserved bits read as zero
          if (!cbWrite && execOk && hitStatus) begin
            rdData_nxt = status_r & STATUS_IMPL;
          end else if (!cbWrite && execOk && hitMask) begin
            rdData_nxt = mask_r & MASK_IMPL;
          end
        end
      end
      ESR_ACK: begin
        // requests during the ack cycle are still served
        state_nxt = ESR_IDLE;
        if (cbReq) begin
          ack_nxt = 1'b1;
          state_nxt = ESR_ACK;
          rdData_nxt = 8'h00;
          if (!cbWrite && execOk && hitStatus) begin
            rdData_nxt = status_r & STATUS_IMPL;
          end else if (!cbWrite && execOk && hitMask) begin
            rdData_nxt = mask_r & MASK_IMPL;
          end
        end
      end
      default: begin
        state_nxt = ESR_IDLE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // registers

  // all state lands here; nothing is computed in this process
  always_ff @(posedge clock) begin
    if (rst) begin
      status_r <= STATUS_RESET;
      mask_r <= MASK_RESET;
      rdData_r <= 8'h00;
      ack_r <= 1'b0;
      summary_r <= 1'b0;
      state_r <= ESR_IDLE;
    end else begin
      status_r <= status_nxt;
      mask_r <= mask_nxt;
      rdData_r <= rdData_nxt;
      ack_r <= ack_nxt;
      summary_r <= summary_nxt;
      state_r <= state_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // outputs straight from flip-flops

  assign cbRdData = rdData_r;
  assign cbAck = ack_r;
  assign exceptionSummaryIrq = summary_r;
endmodule

// [design/esr_parity_chk.sv]
// odd parity checker for one byte lane
`timescale 1ns/1ps
module esr_parity_chk (
  data,
  parity,
  enable,
  parityErr
);
  input wire logic [7:0] data;   // byte under check
  input wire logic parity;       // parity bit sent with it
  input wire logic enable;       // checking switched on
  output logic parityErr;        // high when the nine bits are even

  // odd parity: data and parity together must hold an odd count of ones
  always_comb begin
    parityErr = enable & ~(^{data, parity});
  end
endmodule

// [verification/esr_cmp_model.sv]
// processor side compare register feeding conditional writes
`timescale 1ns/1ps
module esr_cmp_model (
  input wire logic clock,
  input wire logic load,
  input wire logic [7:0] value,
  output logic [7:0] compareValue
);
  // software keeps here what it last read; stale copies make writes fail
  always_ff @(posedge clock) begin
    if (load) begin
      compareValue <= value;
    end
  end
endmodule

// [verification/esr_exception_bank_assertions.sv]
// checker for the exception register bank control bus
`timescale 1ns/1ps
module esr_exception_bank_assertions import esr_pkg::*; (
  input wire logic clock,
  input wire logic rst,
  input wire logic cbReq,
  input wire logic cbWrite,
  input wire logic [7:0] cbAddr,
  input wire logic cbIllegal,
  input wire logic [7:0] cbRdData,
  input wire logic cbAck,
  input wire logic exceptionSummaryIrq
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // a legal status read, shared by several checks
  wire logic rdSt = cbReq && !cbWrite && !cbIllegal &&
    cbAddr == EXC_STATUS_ADDR;
  // a legal mask read
  wire logic rdMk = cbReq && !cbWrite && !cbIllegal &&
    cbAddr == EXC_MASK_ADDR;
  //////////////////////////////////////////////////////////////////////////
  ack_follows_req_a: assert property (cbReq |=> cbAck)
    else $error("no acknowledge after request");
  ack_has_cause_a: assert property (cbAck |-> $past(cbReq))
    else $error("acknowledge without request");
  illegal_reads_zero_a: assert property (cbReq && cbIllegal |=>
    cbRdData == 8'h00) else $error("illegal access returned data");
  illegal_sets_flag_a: assert property (cbReq && cbIllegal ##1 rdSt
    |=> cbRdData[CMD_ERR_BIT]) else $error("command error not latched");
  reserved_zero_a: assert property (rdSt |=>
    (cbRdData & ~STATUS_IMPL) == 8'h00) else $error("reserved bit set");
  mask_top_zero_a: assert property (rdMk |=> !cbRdData[CWI_BIT])
    else $error("mask bit 7 reads one");
  unmapped_zero_a: assert property (cbReq && !cbWrite &&
    cbAddr != EXC_STATUS_ADDR && cbAddr != EXC_MASK_ADDR |=>
    cbRdData == 8'h00) else $error("unmapped read not zero");
  summary_holds_a: assert property ($fell(exceptionSummaryIrq) |->
    $past(cbReq && cbWrite)) else $error("summary dropped by itself");
  // main scenarios reached
  cover property (cbReq && cbIllegal);
  cover property ($rose(exceptionSummaryIrq));
  cover property (rdSt ##1 cbRdData[CWI_BIT]);
endmodule
bind esr_exception_bank esr_exception_bank_assertions chk (.clock(clock),
  .rst(rst), .cbReq(cbReq), .cbWrite(cbWrite), .cbAddr(cbAddr),
  .cbIllegal(cbIllegal), .cbRdData(cbRdData), .cbAck(cbAck),
  .exceptionSummaryIrq(exceptionSummaryIrq));

// [verification/esr_exception_bank_tb.sv]
// self-checking bench for the exception register bank
`timescale 1ns/1ps
module esr_exception_bank_tb import esr_pkg::*;;
  logic clock = '0, rst = 1'b1, cmpLoad = 1'b1;
  logic [7:0] phyIndicateData = '0, cbAddr = '0, ctrlBusData = '0;
  logic phyIndicateParity = '0, phyDataValid = '0, phyParityEnable = '0;
  logic ctrlBusParityEnable = '0, cbReq = '0, cbWrite = '0;
  logic ctrlBusParity = '0, cbIllegal = '0, condWriteTarget = '0;
  logic condWriteDone = '0, condWriteMatch = '0, cbAck, exceptionSummaryIrq;
  logic [7:0] cmpVal = '0, compareValue, cbRdData, st = '0, mk = '0;
  logic [8:0] expQ[$], note; // care bit and expected read data
  logic [31:0] lf = 32'h0001446a;
  int n_fail = 0, checks_done = 0;
  always #2 clock = ~clock;
  esr_exception_bank uut (.clock, .rst, .phyIndicateData,
    .phyIndicateParity, .phyDataValid, .phyParityEnable,
    .ctrlBusParityEnable, .cbReq, .cbWrite, .cbAddr, .ctrlBusData,
    .ctrlBusParity, .cbIllegal, .compareValue, .condWriteTarget,
    .condWriteDone, .condWriteMatch, .cbRdData, .cbAck, .exceptionSummaryIrq);
  esr_cmp_model cmp (.clock(clock), .load(cmpLoad), .value(cmpVal),
    .compareValue(compareValue));
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string n, input logic [7:0] s, e);
    checks_done++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one request; left raised so calls run back to back
  task automatic acc(input logic w, input logic [7:0] a, d,
    input logic bp, il, input logic [7:0] e);
    @(negedge clock);
    {cbReq, cbWrite, cbAddr, ctrlBusData, cbIllegal} = {1'b1, w, a, d, il};
    ctrlBusParity = ~^d ^ bp;
    expQ.push_back({~w, e});
  endtask
  task automatic idle;
    @(negedge clock);
    {cbReq, cbIllegal} = 2'b00;
  endtask
  task automatic phy(input logic [7:0] d, input logic bp);
    @(negedge clock);
    {phyDataValid, phyIndicateData} = {1'b1, d};
    phyIndicateParity = ~^d ^ bp;
    @(negedge clock);
    {phyDataValid, phyIndicateData} = {1'b0, ~d}; // old byte not held
  endtask
  task automatic sum;
    chk("summary", {7'h00, exceptionSummaryIrq}, {7'h00, |(st & mk)});
  endtask
  //////////////////////////////////////////////////////////////////////////
  // matches each acknowledge with the oldest note
  always @(negedge clock) begin
    if (cbAck === 1'b1) begin
      if (expQ.size() == 0) chk("spareAck", 8'h01, 8'h00);
      else begin
        note = expQ.pop_front();
        if (note[8]) chk("rdData", cbRdData, note[7:0]);
      end
    end
  end
  initial begin
    repeat (3000) @(posedge clock);
    chk("timeout", 8'h01, 8'h00);
    finish_test();
  end
  initial begin
    repeat (8) @(negedge clock);
    rst = 1'b0;
    acc(0, EXC_STATUS_ADDR, 0, 0, 0, 0);
    acc(0, EXC_MASK_ADDR, 0, 0, 0, 0);
    acc(0, 8'h10, 0, 0, 0, 0);
    idle();
    phy(8'h5a, 1);
    phyParityEnable = 1'b1;
    repeat (8) begin
      lf = lfsr(lf);
      phy(lf[7:0], 0);
    end
    acc(0, EXC_STATUS_ADDR, 0, 0, 0, st);
    idle();
    phy(8'h3c, 1);
    st[PHY_PAR_BIT] = 1'b1;
    lf = lfsr(lf);
    mk = (lf[7:0] | 8'h01) & MASK_IMPL;
    acc(1, EXC_MASK_ADDR, lf[7:0] | 8'h01, 1, 0, 0);
    acc(0, EXC_STATUS_ADDR, 0, 0, 0, st);
    acc(0, EXC_MASK_ADDR, 0, 0, 0, mk);
    idle();
    sum();
    ctrlBusParityEnable = 1'b1;
    acc(1, EXC_MASK_ADDR, 8'h00, 1, 0, 0);
    st[CB_PAR_BIT] = 1'b1;
    acc(0, EXC_MASK_ADDR, 0, 0, 0, mk);
    acc(0, EXC_STATUS_ADDR, 0, 0, 1, 8'h00);
    st[CMD_ERR_BIT] = 1'b1;
    acc(0, EXC_STATUS_ADDR, 0, 0, 0, st);
    idle();
    cmpVal = st ^ 8'h01; // stale compare copy
    acc(1, EXC_STATUS_ADDR, 8'h00, 0, 0, 0);
    st[CWI_BIT] = 1'b1;
    acc(0, EXC_STATUS_ADDR, 0, 0, 0, st);
    idle();
    sum();
    cmpVal = st;
    acc(1, EXC_STATUS_ADDR, 8'h00, 0, 0, 0);
    st = '0;
    acc(1, EXC_MASK_ADDR, 8'hff, 0, 0, 0);
    mk = MASK_IMPL;
    idle();
    sum();
    for (int i = 0; i < 2; i++) begin
      @(negedge clock);
      {condWriteTarget, condWriteDone, condWriteMatch} = {2'b11, i == 0};
      @(negedge clock);
      {condWriteTarget, condWriteDone} = 2'b00;
      acc(0, EXC_STATUS_ADDR, 0, 0, 0, {i == 1, 7'h00});
      idle();
    end
    st[CWI_BIT] = 1'b1;
    acc(0, EXC_MASK_ADDR, 0, 0, 0, mk);
    idle();
    sum();
    for (int i = 0; i < 10 && expQ.size() != 0; i++) @(negedge clock);
    chk("pending", 8'(expQ.size()), 8'h00);
    finish_test();
  end
endmodule
